// ---- core/pfd_regs.svh ----
// Purpose: constants for the power failure detector
// Assumes: 125 MHz system clock
// Notes: none
// Overview of operation
// [R1] Power-on clear sets the carry disable flip-flop.
// [R2] A read of the timer carry flag clears the carry disable flip-flop.
// [R3] While carry disable is set, set pulses cannot set the timer carry flag.
// [R4] After power-on the flag starts cleared and stays unsettable until first read.
// [R5] After that first read, each rising edge of the set pulse sets the flag.
// [R6] Reading the flag clears it, so a pending carry is consumed.
// [R7] Firmware tests the flag at reset: zero means power failure, one means chip-enable reset.
// [R8] On power failure firmware initialises data memory and output ports.
// [R9] Firmware reads the flag before the next set pulse edge after starting at address zero.
// [R10] Firmware finishes clock update before the next set pulse edge.
// [R11] Firmware finishes failure detection and initialisation within one set period.
// [R12] After power-on or chip-enable rise from clock-stop, oscillation starts then a forced halt of about 125 ms.
// [R13] Chip-enable rising during clock update causes a chip-enable reset that aborts it.
// [R14] Power-on reset starts execution at address zero.
// [R15] After chip-enable rises, the program restarts at address zero on the next set pulse edge.
// [R16] A stop with chip-enable low enters clock-stop; chip-enable rising later restarts via chip-enable reset.
`ifndef PFD_REGS_SVH
`define PFD_REGS_SVH
`define PFD_HALT_MS 125
`define PFD_CLK_MHZ 125
`define PFD_HALT_CYC (`PFD_HALT_MS * 1000 * `PFD_CLK_MHZ)
`define PFD_RESET_VEC 11'h000
`define PFD_DIS_RST 1'b1
`define PFD_FLAG_RST 1'b0
`endif

// ---- core/pfd_pkg.sv ----
// Purpose: types for the power failure detector
// Assumes: nothing
// Notes: none
package pfd_pkg;
    typedef enum logic [2:0] {
        PFD_ST_OFF = 3'b000,
        PFD_ST_HALT = 3'b001,
        PFD_ST_RUN = 3'b010,
        PFD_ST_STOP = 3'b011,
        PFD_ST_CEWAIT = 3'b100
    } pfd_state_t;
    typedef struct packed {
        logic run;
        logic osc_en;
        logic cpu_reset;
        logic [10:0] start_addr;
    } pfd_ctl_t;
endpackage : pfd_pkg

// ---- core/pfd_sync.sv ----
// Purpose: two-stage synchroniser for pin inputs
// Assumes: single clock
// Notes: first stage is read only by the second
`timescale 1ns/100ps
module pfd_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    if (W < 1) begin : g_bad_width
        $error("W must be at least 1");
    end

    logic [W-1:0] s1_r;
    logic [W-1:0] s1_nxt;
    logic [W-1:0] q_nxt;
    always_comb begin
        s1_nxt = d;
        q_nxt = s1_r;
    end
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= '0;
            q <= '0;
        end else begin
            s1_r <= s1_nxt;
            q <= q_nxt;
        end
    end
endmodule : pfd_sync

// ---- core/pfd_top.sv ----
// Purpose: carry flag power failure detection and reset start control
// Assumes: RST is the power-on clear, CE and set pulse are pins
// Notes: forced halt count is a parameter for short simulation
`timescale 1ns/100ps
`include "pfd_regs.svh"
module pfd_top #(
    parameter int HALT_CYC = `PFD_HALT_CYC
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic SET_PULSE,
    input wire logic FLAG_RD,
    input wire logic STOP_REQ,
    input wire logic CLK_UPDATE,
    output logic TIMER_CARRY_FLAG,
    output logic CARRY_DISABLE,
    output pfd_pkg::pfd_ctl_t CTL,
    output logic CE_ABORT
);
    // the halt counter needs room for a first and a last cycle
    if (HALT_CYC < 2) begin : g_bad_halt
        $error("HALT_CYC too small");
    end

    logic ce_s;
    logic sp_s;
    pfd_sync #(.W(2)) u_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .d({CE, SET_PULSE}),
        .q({ce_s, sp_s})
    );

    logic ce_d_r, ce_d_nxt, sp_d_r, sp_d_nxt;
    logic ce_rise, sp_rise;
    assign ce_rise = ce_s & ~ce_d_r;
    assign sp_rise = sp_s & ~sp_d_r;

    // flag and disable flip-flop
    logic flag_r, flag_nxt, dis_r, dis_nxt;
    logic flag_read;
    always_comb begin
        dis_nxt = dis_r;
        flag_nxt = flag_r;
        if (flag_read) begin
            dis_nxt = 1'b0; // R2
            flag_nxt = 1'b0; // R6
        end
        // set wins over the read clear, keeping the carry
        if (sp_rise && !dis_r) flag_nxt = 1'b1; // R3 R5
    end

    // reset and start sequencing
    pfd_pkg::pfd_state_t st_r, st_nxt;
    logic [31:0] cnt_r, cnt_nxt;
    logic rst_pulse_r, rst_pulse_nxt;
    logic abort_r, abort_nxt;
    pfd_pkg::pfd_ctl_t ctl_r, ctl_nxt;
    assign flag_read = FLAG_RD && (st_r == pfd_pkg::PFD_ST_RUN);
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        rst_pulse_nxt = 1'b0;
        abort_nxt = 1'b0;
        ce_d_nxt = ce_s;
        sp_d_nxt = sp_s;
        unique case (st_r)
            pfd_pkg::PFD_ST_OFF: begin
                st_nxt = pfd_pkg::PFD_ST_HALT;
                cnt_nxt = '0;
            end
            pfd_pkg::PFD_ST_HALT: begin
                // halt runs fixed length; a ce rise here is covered by it
                if (cnt_r == 32'(HALT_CYC - 1)) begin // R12
                    st_nxt = pfd_pkg::PFD_ST_RUN;
                    rst_pulse_nxt = 1'b1; // R14
                end else begin
                    cnt_nxt = cnt_r + 32'h1;
                end
            end
            pfd_pkg::PFD_ST_RUN: begin
                if (ce_rise) begin
                    st_nxt = pfd_pkg::PFD_ST_CEWAIT;
                    abort_nxt = CLK_UPDATE; // R13
                end else if (STOP_REQ && !ce_s) begin
                    st_nxt = pfd_pkg::PFD_ST_STOP; // R16
                end
            end
            pfd_pkg::PFD_ST_STOP: begin
                if (ce_rise) begin
                    st_nxt = pfd_pkg::PFD_ST_OFF; // R16 R12
                end
            end
            pfd_pkg::PFD_ST_CEWAIT: begin
                if (sp_rise) begin
                    st_nxt = pfd_pkg::PFD_ST_RUN;
                    rst_pulse_nxt = 1'b1; // R15
                end
            end
            default: st_nxt = pfd_pkg::PFD_ST_OFF;
        endcase
        // decoded from the next state so the outputs leave a register
        ctl_nxt.run = (st_nxt == pfd_pkg::PFD_ST_RUN);
        ctl_nxt.osc_en = (st_nxt != pfd_pkg::PFD_ST_STOP); // R12 R16
        ctl_nxt.cpu_reset = rst_pulse_nxt || (st_nxt != pfd_pkg::PFD_ST_RUN);
        ctl_nxt.start_addr = `PFD_RESET_VEC; // R14 R15
    end

    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            dis_r <= `PFD_DIS_RST; // R1
            flag_r <= `PFD_FLAG_RST; // R4
            st_r <= pfd_pkg::PFD_ST_OFF;
            cnt_r <= '0;
            rst_pulse_r <= 1'b0;
            abort_r <= 1'b0;
            ce_d_r <= 1'b0;
            sp_d_r <= 1'b0;
            ctl_r <= '{run: 1'b0, osc_en: 1'b1, cpu_reset: 1'b1, start_addr: `PFD_RESET_VEC};
        end else begin
            dis_r <= dis_nxt;
            flag_r <= flag_nxt;
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            rst_pulse_r <= rst_pulse_nxt;
            abort_r <= abort_nxt;
            ce_d_r <= ce_d_nxt;
            sp_d_r <= sp_d_nxt;
            ctl_r <= ctl_nxt;
        end
    end

    assign TIMER_CARRY_FLAG = flag_r;
    assign CARRY_DISABLE = dis_r;
    assign CE_ABORT = abort_r;
    assign CTL = ctl_r;

    sequence s_disabled;
        dis_r;
    endsequence
    sequence s_halt_last;
        st_r == pfd_pkg::PFD_ST_HALT && cnt_r == 32'(HALT_CYC - 1);
    endsequence
    sequence s_restart;
        CTL.run && rst_pulse_r;
    endsequence
    sequence s_stop_wake;
        st_r == pfd_pkg::PFD_ST_STOP && ce_rise;
    endsequence
    sequence s_cold_start;
        st_r == pfd_pkg::PFD_ST_OFF ##1 st_r == pfd_pkg::PFD_ST_HALT;
    endsequence

    // flag and disable flip-flop
    a_dis_blocks_set: assert property (@(posedge SYS_CLK) disable iff (RST) // R3
        s_disabled |=> !flag_r || $past(flag_r))
        else $error("flag set while disabled");
    a_read_clears_dis: assert property (@(posedge SYS_CLK) disable iff (RST) // R2
        flag_read |=> !dis_r)
        else $error("disable not cleared by read");
    a_set_after_read: assert property (@(posedge SYS_CLK) disable iff (RST) // R5
        (sp_rise && !dis_r) |=> flag_r)
        else $error("flag not set on pulse");
    a_read_clears_flag: assert property (@(posedge SYS_CLK) disable iff (RST) // R6
        (flag_read && !sp_rise) |=> !flag_r)
        else $error("flag not cleared by read");
    a_por_state: assert property (@(posedge SYS_CLK) // R1 R4
        RST |=> dis_r && !flag_r)
        else $error("bad power-on state");
    a_dis_stays_clear: assert property (@(posedge SYS_CLK) disable iff (RST) // R1
        !dis_r |=> !dis_r)
        else $error("disable set without power-on clear");
    a_read_refused: assert property (@(posedge SYS_CLK) disable iff (RST) // R2
        (FLAG_RD && !CTL.run) |=> $stable(dis_r))
        else $error("read honoured outside run");
    a_flag_no_spurious: assert property (@(posedge SYS_CLK) disable iff (RST) // R3 R5
        (!flag_r && !sp_rise) |=> !flag_r)
        else $error("flag set without pulse");

    // start sequencing
    a_halt_start: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
        (st_r == pfd_pkg::PFD_ST_OFF) |=> st_r == pfd_pkg::PFD_ST_HALT && cnt_r == 32'h0)
        else $error("halt not started");
    a_halt_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
        (st_r == pfd_pkg::PFD_ST_HALT && cnt_r != 32'(HALT_CYC - 1)) |=> !CTL.run)
        else $error("halt left early");
    a_halt_release: assert property (@(posedge SYS_CLK) disable iff (RST) // R12 R14
        s_halt_last |=> s_restart)
        else $error("halt end without restart");
    a_osc_in_halt: assert property (@(posedge SYS_CLK) disable iff (RST) // R12
        (st_r == pfd_pkg::PFD_ST_HALT) |-> CTL.osc_en)
        else $error("oscillator off in halt");
    a_pulse_single: assert property (@(posedge SYS_CLK) disable iff (RST) // R14
        rst_pulse_r |=> !rst_pulse_r)
        else $error("restart pulse too long");

    // chip-enable reset and abort
    a_abort_cause: assert property (@(posedge SYS_CLK) disable iff (RST) // R13
        CE_ABORT |-> $past(CLK_UPDATE) && $past(ce_rise))
        else $error("bad abort");
    a_abort_update: assert property (@(posedge SYS_CLK) disable iff (RST) // R13
        (CTL.run && ce_rise && CLK_UPDATE) |=> CE_ABORT)
        else $error("update not aborted");
    a_abort_single: assert property (@(posedge SYS_CLK) disable iff (RST) // R13
        CE_ABORT |=> !CE_ABORT)
        else $error("abort too long");
    a_ce_restart: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
        (st_r == pfd_pkg::PFD_ST_CEWAIT && sp_rise) |=> s_restart)
        else $error("ce restart missed");
    a_ce_wait_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // R15
        (st_r == pfd_pkg::PFD_ST_CEWAIT && !sp_rise) |=> !CTL.run && CTL.cpu_reset)
        else $error("restart before set pulse");

    // clock-stop
    a_stop_entry: assert property (@(posedge SYS_CLK) disable iff (RST) // R16
        (CTL.run && !ce_rise && STOP_REQ && !ce_s) |=> !CTL.osc_en)
        else $error("stop not entered");
    a_stop_hold: assert property (@(posedge SYS_CLK) disable iff (RST) // R16
        (st_r == pfd_pkg::PFD_ST_STOP && !ce_rise) |=> !CTL.osc_en)
        else $error("stop left without ce rise");
    a_stop_wake: assert property (@(posedge SYS_CLK) disable iff (RST) // R16 R12
        s_stop_wake |=> s_cold_start)
        else $error("stop wake without halt");
endmodule : pfd_top

// ---- dv/pfd_pulse_model.sv ----
// Purpose: far-side source of the carry flag set pulse
// Assumes: one request gives one pulse of WIDTH clocks
// Notes: line idles low between pulses, like the real pin
`timescale 1ns/100ps
module pfd_pulse_model #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic fire,
    output logic set_pulse
);
    int cnt = 0;
    always @(posedge clk) begin
        cnt <= fire ? WIDTH : (cnt > 0 ? cnt - 1 : 0);
    end
    assign set_pulse = (cnt != 0);
endmodule : pfd_pulse_model

// ---- dv/pfd_top_tb_top.sv ----
// Purpose: self-checking bench for the power failure detector
// Assumes: short forced halt, inputs driven on the falling edge
// Notes: firmware role played by the scenario tasks
`timescale 1ns/100ps
module pfd_top_tb_top;
    localparam int HALT = 20;
    logic sys_clk = 0, rst = 1, ce = 0, rd = 0, stp = 0, upd = 0, fire = 0;
    logic set_pulse, flag, dis, abort, seen;
    pfd_pkg::pfd_ctl_t ctl;
    int num_errors = 0;
    int num_checks = 0;
    always #4 sys_clk = ~sys_clk;
    pfd_pulse_model u_pfd_pulse_model (.clk(sys_clk), .fire(fire), .set_pulse(set_pulse));
    pfd_top #(.HALT_CYC(HALT)) u_pfd_top (.SYS_CLK(sys_clk), .RST(rst), .CE(ce),
        .SET_PULSE(set_pulse), .FLAG_RD(rd), .STOP_REQ(stp), .CLK_UPDATE(upd),
        .TIMER_CARRY_FLAG(flag), .CARRY_DISABLE(dis), .CTL(ctl), .CE_ABORT(abort));
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [10:0] got, input logic [10:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : cyc
    task automatic pulse_set();
        fire = 1;
        cyc(1);
        fire = 0;
        cyc(6);
    endtask : pulse_set
    task automatic read_flag();
        rd = 1;
        cyc(1);
        rd = 0;
        cyc(1);
    endtask : read_flag
    // bounded wait; a hang ends the run as a mismatch
    task automatic wait_run();
        for (int i = 0; i < HALT + 40 && ctl.run !== 1'b1; i++) cyc(1);
        if (ctl.run !== 1'b1) begin
            num_errors++;
            complete_run();
        end
    endtask : wait_run
    task automatic t_power_on();
        cyc(5);
        chk(dis, 1'b1);
        chk(flag, 1'b0);
        chk(ctl.cpu_reset, 1'b1);
        cyc(1);
        rst = 0;
        cyc(HALT / 2);
        read_flag();
        chk(dis, 1'b1);
        chk(ctl.run, 1'b0);
        chk(ctl.osc_en, 1'b1);
        wait_run();
        chk(ctl.start_addr, 11'h000);
        chk(dis, 1'b1);
    endtask : t_power_on
    task automatic t_flag_cycle();
        pulse_set();
        chk(flag, 1'b0);
        read_flag();
        chk(dis, 1'b0);
        chk(flag, 1'b0);
        pulse_set();
        chk(flag, 1'b1);
        read_flag();
        chk(flag, 1'b0);
        upd = 1;
        cyc(2);
        upd = 0;
        chk(abort, 1'b0);
        pulse_set();
        chk(flag, 1'b1);
    endtask : t_flag_cycle
    task automatic t_ce_reset();
        upd = 1;
        ce = 1;
        seen = 0;
        repeat (8) begin
            cyc(1);
            seen = seen | abort;
        end
        chk(seen, 1'b1);
        upd = 0;
        chk(ctl.run, 1'b0);
        chk(ctl.cpu_reset, 1'b1);
        fire = 1;
        seen = 0;
        repeat (10) begin
            cyc(1);
            fire = 0;
            seen = seen | (ctl.run & ctl.cpu_reset);
        end
        chk(seen, 1'b1);
        wait_run();
        chk(flag, 1'b1);
    endtask : t_ce_reset
    task automatic t_stop();
        ce = 0;
        cyc(4);
        stp = 1;
        cyc(1);
        stp = 0;
        cyc(3);
        chk(ctl.osc_en, 1'b0);
        ce = 1;
        wait_run();
        chk(ctl.osc_en, 1'b1);
        chk(dis, 1'b0);
    endtask : t_stop
    // second power-on clear in mid-run must re-arm the detection
    task automatic t_power_fail();
        rst = 1;
        cyc(3);
        chk(dis, 1'b1);
        chk(flag, 1'b0);
        chk(ctl.cpu_reset, 1'b1);
        rst = 0;
        wait_run();
        chk(flag, 1'b0);
        read_flag();
        cyc(2);
        chk(dis, 1'b0);
        pulse_set();
        chk(flag, 1'b1);
    endtask : t_power_fail
    initial begin
        t_power_on();
        t_flag_cycle();
        t_ce_reset();
        t_stop();
        t_power_fail();
        complete_run();
    end
endmodule : pfd_top_tb_top
